// file: design/secc_params.svh
// Constants for the serial EEPROM command core
`ifndef SECC_PARAMS_SVH
`define SECC_PARAMS_SVH

// Status byte field positions
`define SECC_ST_BUSY    0
`define SECC_ST_LATCH   1
`define SECC_ST_BP_LO   2
`define SECC_ST_BP_HI   3
`define SECC_ST_STANDBY 5
`define SECC_ST_AUTO_OFF 6
`define SECC_ST_LOCK    7

// Reset values of the status fields
`define SECC_RST_BP     2'h0
`define SECC_RST_FLAG   1'b0

// Array geometry
`define SECC_ADDR_W     15
`define SECC_MEM_WORDS  32768
`define SECC_PAGE_BYTES 64

// Internal write cycle, time and derived core clock count (longest: floor)
`define SECC_CLK_PERIOD_NS  100
`define SECC_WRITE_TIME_NS  100000
`define SECC_WRITE_CYCLES   (`SECC_WRITE_TIME_NS / `SECC_CLK_PERIOD_NS)

`endif

// file: design/secc_pkg.sv
// Types shared by the serial EEPROM command core
package secc_pkg;

  typedef enum logic [7:0] {
    SECC_OP_STATUS_UPDATE = 8'h01,
    SECC_OP_PROGRAM       = 8'h02,
    SECC_OP_READ          = 8'h03,
    SECC_OP_LATCH_DISABLE = 8'h04,
    SECC_OP_STATUS_READ   = 8'h05,
    SECC_OP_LATCH_ENABLE  = 8'h06,
    SECC_OP_FAST_READ     = 8'h0b
  } secc_cmd_e;

  typedef enum logic [2:0] {
    SECC_IDLE       = 3'b000,
    SECC_CMD        = 3'b001,
    SECC_ADDR       = 3'b010,
    SECC_DUMMY      = 3'b011,
    SECC_READ       = 3'b100,
    SECC_STATUS_IN  = 3'b101,
    SECC_PROG_DATA  = 3'b110,
    SECC_DONE       = 3'b111
  } secc_state_e;

  typedef logic [7:0] secc_byte_t;

endpackage : secc_pkg

// file: design/secc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module secc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // Reset level is a fixed constant per bit, loaded by a clocked process
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta     <= '1;
      sync_out <= '1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : secc_sync

// file: design/secc_core.sv
// Serial EEPROM command core: link decode, status, reads and page program
// Overview of operation
// RULE_01: Enable latch is clear after reset; programs refused until enable opcode 06h.
// RULE_02: Latch clears after successful disable, status update or program.
// RULE_03: Chip select rising mid-byte means not executed; latch untouched.
// RULE_04: Opcode 04h clears the enable latch whatever the protect pin shows.
// RULE_05: Opcode 05h shifts out status: busy, latch and protection bits.
// RULE_06: Opcode 01h updates only protect, power-down, standby and lock bits.
// RULE_07: With protect pin low and lock set, the status update is refused.
// RULE_08: Read takes a 16-bit address; only the low 15 bits are used.
// RULE_09: After read address, input is ignored; byte shifts out bit 7 first.
// RULE_10: Reads auto-increment the address and wrap to zero while selected.
// RULE_11: Fast read 0Bh takes address then 8 dummy bits before data.
// RULE_12: Host ends a single-byte read by raising chip select.
// RULE_13: Host sends enable, releases select, then 02h, address and data.
// RULE_14: Select rising right after a whole data byte starts the write cycle.
// RULE_15: During the write cycle every command but status read is ignored.
// RULE_16: Status bit 0 reads one while the write cycle runs.
// RULE_17: Program increments only the six low address bits, wrapping in page.
// RULE_18: Last 64 bytes win; unwritten bytes of the page stay unchanged.
// RULE_19: Program with latch clear is ignored until a new select fall.
// RULE_20: Latch is set only on select rising after the enable opcode.
// RULE_21: Protect bits guard none, top quarter, top half or whole array.
// RULE_22: MSB first, sample on rising clock, drive on falling clock.
`timescale 1ns/10ps
`include "secc_params.svh"
module secc_core
  import secc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `SECC_WRITE_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  input  wire logic cs_n_in,
  input  wire logic sck_in,
  input  wire logic serial_in_in,
  input  wire logic protect_n_in,
  output logic      serial_out_out,
  output logic      serial_out_oe_out,
  output logic      busy_flag_out,
  output logic      program_enable_latch_out
);
  localparam int AW = `SECC_ADDR_W;

  logic [3:0]    pins_s;
  logic          cs_s;
  logic          sck_s;
  logic          ser_in_s;
  logic          wp_n_s;
  logic          cs_d;
  logic          sck_d;
  logic          sck_rise;
  logic          sck_fall;
  logic          cs_rise;
  logic          cs_fall;

  logic [2:0]    bit_cnt;
  logic [6:0]    shift_q;
  secc_byte_t    in_byte;
  logic          byte_done;
  logic          whole;

  secc_state_e   state;
  secc_byte_t    opcode;
  logic          addr_second;
  logic [AW-1:0] addr;
  logic [AW-1:0] rd_addr;
  secc_byte_t    status_new;
  logic          got_data;
  logic [`SECC_PAGE_BYTES-1:0] page_mask;

  logic          program_enable_latch;
  logic [1:0]    bp;
  logic          low_power_standby_enable;
  logic          auto_power_down_enable;
  logic          lock;
  logic          busy;
  logic [15:0]   timer;
  logic [5:0]    wr_idx;
  logic [AW-7:0] page_base;
  secc_byte_t    status_byte;

  logic          prot_hit;
  logic          exec_latch_en;
  logic          exec_latch_dis;
  logic          exec_status_upd;
  logic          exec_prog;
  logic          tx_load;
  secc_byte_t    tx_data;
  secc_byte_t    tx_byte;
  logic [2:0]    tx_pos;
  logic          tx_active;

  secc_byte_t    mem      [0:`SECC_MEM_WORDS-1];
  secc_byte_t    page_buf [0:`SECC_PAGE_BYTES-1];

  // Chip select and clock idle high after reset so no false edge is seen
  secc_sync #(.WIDTH(4)) u_sync (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .async_in    ({cs_n_in, sck_in, serial_in_in, protect_n_in}),
    .rst_val_in  (4'hf),
    .sync_out    (pins_s)
  );
  assign cs_s     = pins_s[3];
  assign sck_s    = pins_s[2];
  assign ser_in_s = pins_s[1];
  assign wp_n_s   = pins_s[0];

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_d  <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      cs_d  <= cs_s;
      sck_d <= sck_s;
    end
  end

  // Clock edges count only while selected; mode 0 and 3 both work [RULE_22]
  assign sck_rise = sck_s & ~sck_d & ~cs_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_s;
  assign cs_rise  = cs_s & ~cs_d;
  assign cs_fall  = ~cs_s & cs_d;

  assign in_byte   = {shift_q, ser_in_s};
  assign byte_done = sck_rise && (bit_cnt == 3'h7);
  assign whole     = (bit_cnt == 3'h0); // [RULE_03]

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_cnt <= 3'h0;
      shift_q <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_q <= {shift_q[5:0], ser_in_s}; // [RULE_22]
    end
  end

  assign status_byte = {lock, auto_power_down_enable,
                        low_power_standby_enable, 1'b0, bp,
                        program_enable_latch, busy}; // [RULE_05]

  // Top quarter and top half follow the high address bits [RULE_21]
  always_comb begin
    prot_hit = 1'b0;
    if (bp == 2'h1) begin
      prot_hit = (addr[AW-1:AW-2] == 2'h3);
    end else if (bp == 2'h2) begin
      prot_hit = addr[AW-1];
    end else if (bp == 2'h3) begin
      prot_hit = 1'b1;
    end
  end

  assign exec_latch_en   = cs_rise && whole && (state == SECC_DONE)
                           && (opcode == SECC_OP_LATCH_ENABLE);
  assign exec_latch_dis  = cs_rise && whole && (state == SECC_DONE)
                           && (opcode == SECC_OP_LATCH_DISABLE);
  assign exec_status_upd = cs_rise && whole && (state == SECC_DONE)
                           && (opcode == SECC_OP_STATUS_UPDATE);
  assign exec_prog = cs_rise && whole && (state == SECC_PROG_DATA)
                     && got_data && !prot_hit; // [RULE_14] [RULE_21]

  // Only the low 15 address bits are kept [RULE_08]
  assign rd_addr = (state == SECC_ADDR) ? {addr[AW-1:8], in_byte} : addr;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state       <= SECC_IDLE;
      opcode      <= 8'h00;
      addr_second <= 1'b0;
      addr        <= '0;
      status_new  <= 8'h00;
      got_data    <= 1'b0;
      page_mask   <= '0;
    end else if (cs_s) begin
      state <= SECC_IDLE;
    end else if (cs_fall) begin
      state       <= SECC_CMD;
      addr_second <= 1'b0;
      got_data    <= 1'b0;
    end else if (byte_done) begin
      case (state)
        SECC_CMD: begin
          opcode <= in_byte;
          if (busy && in_byte != SECC_OP_STATUS_READ) begin
            state <= SECC_IDLE; // [RULE_15]
          end else if (in_byte == SECC_OP_LATCH_ENABLE ||
                       in_byte == SECC_OP_LATCH_DISABLE) begin
            state <= SECC_DONE;
          end else if (in_byte == SECC_OP_STATUS_READ) begin
            state <= SECC_DONE;
          end else if (in_byte == SECC_OP_STATUS_UPDATE) begin // [RULE_20]
            state <= program_enable_latch ? SECC_STATUS_IN : SECC_IDLE;
          end else if (in_byte == SECC_OP_READ ||
                       in_byte == SECC_OP_FAST_READ) begin
            state <= SECC_ADDR;
          end else if (in_byte == SECC_OP_PROGRAM) begin // [RULE_01] [RULE_19]
            state <= program_enable_latch ? SECC_ADDR : SECC_IDLE;
          end else begin
            state <= SECC_IDLE;
          end
        end
        SECC_ADDR: begin
          addr_second <= 1'b1;
          if (!addr_second) begin
            addr[AW-1:8] <= in_byte[6:0]; // [RULE_08]
          end else if (opcode == SECC_OP_READ) begin
            addr  <= rd_addr + 15'h0001;
            state <= SECC_READ;
          end else if (opcode == SECC_OP_FAST_READ) begin
            addr[7:0] <= in_byte;
            state     <= SECC_DUMMY; // [RULE_11]
          end else begin
            addr[7:0] <= in_byte;
            page_mask <= '0;
            state     <= SECC_PROG_DATA;
          end
        end
        SECC_DUMMY: begin
          addr  <= addr + 15'h0001;
          state <= SECC_READ;
        end
        SECC_READ: begin
          addr <= addr + 15'h0001; // [RULE_10]
        end
        SECC_STATUS_IN: begin
          status_new <= in_byte;
          state      <= SECC_DONE;
        end
        SECC_PROG_DATA: begin
          got_data            <= 1'b1;
          page_mask[addr[5:0]] <= 1'b1; // [RULE_18]
          addr[5:0]           <= addr[5:0] + 6'h01; // [RULE_17]
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // Page buffer holds the latest byte per slot; older repeats are overwritten
  always_ff @(posedge core_clk_in) begin
    if (!cs_s && byte_done && state == SECC_PROG_DATA) begin
      page_buf[addr[5:0]] <= in_byte; // [RULE_18]
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      program_enable_latch     <= `SECC_RST_FLAG; // [RULE_01]
      bp                       <= `SECC_RST_BP;
      low_power_standby_enable <= `SECC_RST_FLAG;
      auto_power_down_enable   <= `SECC_RST_FLAG;
      lock                     <= `SECC_RST_FLAG;
    end else if (exec_latch_en) begin
      program_enable_latch <= 1'b1; // [RULE_20]
    end else if (exec_latch_dis) begin
      program_enable_latch <= 1'b0; // [RULE_04] [RULE_02]
    end else if (exec_status_upd) begin
      // Locked with protect pin low: whole update refused, latch kept
      if (!(lock && !wp_n_s)) begin // [RULE_07]
        bp   <= {status_new[`SECC_ST_BP_HI], status_new[`SECC_ST_BP_LO]};
        low_power_standby_enable <= status_new[`SECC_ST_STANDBY]; // [RULE_06]
        auto_power_down_enable   <= status_new[`SECC_ST_AUTO_OFF];
        lock                     <= status_new[`SECC_ST_LOCK];
        program_enable_latch     <= 1'b0; // [RULE_02]
      end
    end else if (exec_prog) begin
      program_enable_latch <= 1'b0; // [RULE_02]
    end
  end

  // Self-timed cycle; the page is copied one slot per clock meanwhile
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy      <= 1'b0;
      timer     <= 16'h0000;
      wr_idx    <= 6'h00;
      page_base <= '0;
    end else if (exec_prog) begin
      busy      <= 1'b1; // [RULE_14] [RULE_16]
      timer     <= 16'(WRITE_CYCLES - 1);
      wr_idx    <= 6'h00;
      page_base <= addr[AW-1:6];
    end else if (busy) begin
      wr_idx <= wr_idx + 6'h01;
      if (timer == 16'h0000) begin
        busy <= 1'b0; // [RULE_16]
      end else begin
        timer <= timer - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (busy && page_mask[wr_idx]) begin
      mem[{page_base, wr_idx}] <= page_buf[wr_idx]; // [RULE_18]
    end
  end

  // Next byte is fetched at each byte boundary during the data phase
  always_comb begin
    tx_load = 1'b0;
    tx_data = mem[rd_addr];
    if (byte_done) begin
      if ((state == SECC_CMD && in_byte == SECC_OP_STATUS_READ) ||
          state == SECC_DONE && opcode == SECC_OP_STATUS_READ) begin
        tx_load = 1'b1;
        tx_data = status_byte; // [RULE_05]
      end else if ((state == SECC_ADDR && addr_second &&
                    opcode == SECC_OP_READ) ||
                   state == SECC_DUMMY || state == SECC_READ) begin
        tx_load = 1'b1; // [RULE_09]
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_byte           <= 8'h00;
      tx_pos            <= 3'h7;
      tx_active         <= 1'b0;
      serial_out_out    <= 1'b0;
      serial_out_oe_out <= 1'b0;
    end else if (cs_s) begin
      tx_active         <= 1'b0;
      serial_out_out    <= 1'b0;
      serial_out_oe_out <= 1'b0; // [RULE_12]
    end else if (tx_load) begin
      tx_byte   <= tx_data;
      tx_pos    <= 3'h7;
      tx_active <= 1'b1;
    end else if (sck_fall && tx_active) begin
      serial_out_out    <= tx_byte[tx_pos]; // [RULE_09] [RULE_22]
      serial_out_oe_out <= 1'b1;
      tx_pos            <= tx_pos - 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_flag_out            <= 1'b0;
      program_enable_latch_out <= 1'b0;
    end else begin
      busy_flag_out            <= busy;
      program_enable_latch_out <= program_enable_latch;
    end
  end
endmodule : secc_core

// file: sim/secc_core_chk.sv
// Port checker for the serial EEPROM command core
`timescale 1ns/10ps
module secc_core_chk #(
  parameter int unsigned WRITE_CYCLES = 1000
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic serial_in_in,
  input wire logic protect_n_in,
  input wire logic serial_out_out,
  input wire logic serial_out_oe_out,
  input wire logic busy_flag_out,
  input wire logic program_enable_latch_out
);
  int unsigned busy_cnt;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Length of the current busy run, checked against the write cycle count
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_flag_out ? busy_cnt + 1 : 0;
    end
  end
  AST_OE_OFF: assert property (
    cs_n_in [*6] |-> !serial_out_oe_out)
    else $error("data out driven while deselected");
  AST_SO_EDGE: assert property (
    serial_out_oe_out && $changed(serial_out_out) |-> !$past(sck_in, 3))
    else $error("data out changed without a clock fall");
  AST_WEL_RISE: assert property (
    $rose(program_enable_latch_out) |-> cs_n_in && $past(cs_n_in, 2))
    else $error("latch set while selected");
  AST_WEL_BUSY: assert property (
    $rose(program_enable_latch_out) |-> !busy_flag_out)
    else $error("latch set during write cycle");
  AST_BUSY_CAUSE: assert property (
    $rose(busy_flag_out) |-> cs_n_in && $past(program_enable_latch_out, 3))
    else $error("write cycle without latch or select rise");
  AST_WEL_CLR: assert property (
    $rose(busy_flag_out) |-> ##[0:2] !program_enable_latch_out)
    else $error("latch not cleared by program");
  AST_BUSY_LEN: assert property (
    $fell(busy_flag_out) |-> busy_cnt == WRITE_CYCLES)
    else $error("write cycle ended early");
  AST_BUSY_MAX: assert property (
    busy_flag_out |-> busy_cnt < WRITE_CYCLES)
    else $error("write cycle too long");
endmodule : secc_core_chk

bind secc_core secc_core_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
  .sck_in(sck_in), .serial_in_in(serial_in_in),
  .protect_n_in(protect_n_in), .serial_out_out(serial_out_out),
  .serial_out_oe_out(serial_out_oe_out), .busy_flag_out(busy_flag_out),
  .program_enable_latch_out(program_enable_latch_out));

// file: sim/secc_host.sv
// Host link controller model: select, serial clock and data
`timescale 1ns/10ps
module secc_host (
  input  wire logic       core_clk_in,
  input  wire logic       serial_out_in,
  input  wire logic       serial_out_oe_in,
  output logic            cs_n_out,
  output logic            sck_out,
  output logic            serial_in_out,
  output logic [7:0]      rx_out
);
  event got;
  logic last;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    serial_in_out = 1'b0;
    rx_out = 8'h00;
    last = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : tick
  // Clock idles low, so select edges fall in mode 0
  task automatic sel();
    tick(1);
    cs_n_out = 1'b0;
    tick(4);
  endtask : sel
  // Rise in the clock low time after the last bit
  task automatic desel();
    tick(2);
    cs_n_out = 1'b1;
    serial_in_out = ~serial_in_out;
    tick(8);
  endtask : desel
  // MSB first, five cycles low then three high: 800 ns
  task automatic shift(input logic [7:0] tx, input int nb, input bit chk);
    for (int i = 7; i > 7 - nb; i--) begin
      serial_in_out = tx[i];
      tick(5);
      // Undriven line gives no stale value back
      last = serial_out_oe_in ? serial_out_in : ~last;
      rx_out = {rx_out[6:0], last};
      sck_out = 1'b1;
      tick(3);
      sck_out = 1'b0;
    end
    if (chk) ->got;
  endtask : shift
endmodule : secc_host

// file: sim/tb_secc_core.sv
// Self-checking bench for the serial EEPROM command core
`timescale 1ns/10ps
module tb_secc_core;
  import secc_pkg::*;
  localparam int unsigned WC = 400;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic wp_n = 1'b1;
  logic cs_n, sck, ser_in, ser_out, oe, busy, latch;
  secc_byte_t rx;
  secc_byte_t exp_q[$];
  secc_byte_t mem[int];
  int miscompares = 0;
  int n_compared = 0;
  secc_core #(.WRITE_CYCLES(WC)) i_dut (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n),
    .sck_in(sck), .serial_in_in(ser_in), .protect_n_in(wp_n),
    .serial_out_out(ser_out), .serial_out_oe_out(oe),
    .busy_flag_out(busy), .program_enable_latch_out(latch));
  secc_host i_host (.core_clk_in(core_clk_in),
    .serial_out_in(ser_out), .serial_out_oe_in(oe), .cs_n_out(cs_n),
    .sck_out(sck), .serial_in_out(ser_in), .rx_out(rx));
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic cmp8(input secc_byte_t got, input secc_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1
  initial begin
    forever begin
      @(i_host.got);
      cmp8(rx, exp_q.pop_front());
    end
  end
  task automatic wr2(input secc_byte_t c, input secc_byte_t d, int nb);
    i_host.sel();
    // nb 0: whole opcode alone, 4: cut opcode, 8: opcode and data byte
    i_host.shift(c, (nb == 0) ? 8 : nb, 1'b0);
    if (nb == 8) i_host.shift(d, 8, 1'b0);
    i_host.desel();
  endtask : wr2
  task automatic stat(input secc_byte_t e);
    i_host.sel();
    i_host.shift(SECC_OP_STATUS_READ, 8, 1'b0);
    exp_q.push_back(e);
    i_host.shift(8'hff, 8, 1'b1);
    i_host.desel();
  endtask : stat
  task automatic hdr(input secc_byte_t c, input logic [14:0] a);
    i_host.sel();
    i_host.shift(c, 8, 1'b0);
    i_host.shift({1'b0, a[14:8]}, 8, 1'b0);
    i_host.shift(a[7:0], 8, 1'b0);
  endtask : hdr
  task automatic prog(input logic [14:0] a, int n, bit en, bit ok);
    secc_byte_t d;
    if (en) wr2(SECC_OP_LATCH_ENABLE, 8'h00, 0);
    hdr(SECC_OP_PROGRAM, a);
    for (int i = 0; i < n; i++) begin
      d = secc_byte_t'($urandom);
      i_host.shift(d, 8, 1'b0);
      if (ok) mem[{a[14:6], 6'(a[5:0] + i)}] = d;
    end
    i_host.desel();
  endtask : prog
  task automatic rd(input secc_byte_t c, input logic [14:0] a, int n);
    hdr(c, a);
    if (c == SECC_OP_FAST_READ) i_host.shift(8'h5a, 8, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[15'(a + i)]);
      i_host.shift(secc_byte_t'($urandom), 8, 1'b1);
    end
    i_host.desel();
  endtask : rd
  task automatic idle();
    for (int k = 0; k < 2 * WC && busy !== 1'b0; k++) begin
      @(negedge core_clk_in);
    end
    cmp1(busy, 1'b0);
  endtask : idle
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #(60000 * 100);
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(22));
    repeat (20) @(negedge core_clk_in);
    rstn_in = 1'b1;
    repeat (5) @(negedge core_clk_in);
    stat(8'h00);
    prog(15'h0200, 1, 1'b0, 1'b0);
    stat(8'h00);
    $display("test reset done");
    wr2(SECC_OP_LATCH_ENABLE, 8'h00, 0);
    cmp1(latch, 1'b1);
    stat(8'h02);
    wr2(SECC_OP_LATCH_DISABLE, 8'h00, 4);
    stat(8'h02);
    wp_n = 1'b0;
    wr2(SECC_OP_LATCH_DISABLE, 8'h00, 0);
    stat(8'h00);
    wp_n = 1'b1;
    $display("test latch done");
    prog(15'h013e, 3, 1'b1, 1'b1);
    cmp1(busy, 1'b1);
    stat(8'h01);
    wr2(SECC_OP_LATCH_ENABLE, 8'h00, 0);
    idle();
    stat(8'h00);
    prog(15'h7fff, 1, 1'b1, 1'b1);
    idle();
    prog(15'h0000, 1, 1'b1, 1'b1);
    idle();
    prog(15'h0200, 66, 1'b1, 1'b1);
    idle();
    rd(SECC_OP_READ, 15'h013e, 2);
    rd(SECC_OP_FAST_READ, 15'h0100, 1);
    rd(SECC_OP_READ, 15'h7fff, 2);
    rd(SECC_OP_FAST_READ, 15'h0200, 3);
    $display("test array done");
    wr2(SECC_OP_LATCH_ENABLE, 8'h00, 0);
    wr2(SECC_OP_STATUS_UPDATE, 8'hff, 8);
    stat(8'hec);
    wp_n = 1'b0;
    wr2(SECC_OP_LATCH_ENABLE, 8'h00, 0);
    wr2(SECC_OP_STATUS_UPDATE, 8'h00, 8);
    stat(8'hee);
    prog(15'h0300, 1, 1'b0, 1'b0);
    stat(8'hee);
    wp_n = 1'b1;
    wr2(SECC_OP_STATUS_UPDATE, 8'h00, 8);
    stat(8'h00);
    $display("test status done");
    report_and_stop();
  end
endmodule : tb_secc_core
